// File: design/fsg_pkg.sv
// constants and types for the flash security id debug gate
// How it works
// - ten id bytes held at fixed flash addresses
// - last byte bit seven permits the emulator
// - full match releases flash read and emulation
// - cleared permission flag refuses debugging despite match
// - pin reset masked for core during break
// - pin reset still resets port buffers
// - software breakpoints off after pin reset while running or watchdog reset, back at break
// - reset while running flags break handling unreliable
// - reset while running during flash dma or monitor flagged
package fsg_pkg;
  localparam int ADDR_W = 24; // flash byte address width
  localparam logic [ADDR_W-1:0] ID_BASE = 24'h000070; // first id byte
  localparam logic [ADDR_W-1:0] ID_LAST = 24'h000079; // last id byte, holds the flag
  localparam logic [3:0] ID_LEN = 4'ha; // id length in bytes
  localparam logic [3:0] ID_LAST_IDX = 4'h9; // index of the flag byte
  localparam int PERM_BIT = 7; // emulator permission bit in last byte
  localparam logic SECURED_RST = 1'b1; // device starts secured
  localparam logic SWBP_RST = 1'b1; // breakpoints usable after reset
  localparam logic PIN_IDLE = 1'b1; // reset pin released level

  // gray codes along idle, fetch, wait, compare, done
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FETCH = 3'h1,
    ST_WAIT = 3'h3,
    ST_CMP = 3'h2,
    ST_DONE = 3'h6
  } fsg_state_t;

  typedef struct packed {
    fsg_state_t st; // authentication sequencer
    logic [3:0] idx; // byte under compare
    logic [7:0] stored; // stored byte just fetched
    logic mismatch; // any byte differed so far
    logic perm; // permission flag from last byte
    logic secured; // flash and emulator locked
    logic rd_en; // flash readout allowed
    logic dbg_en; // emulator allowed
    logic done; // end of an attempt, pulse
    logic fail; // attempt rejected, pulse
    logic flash_rd; // flash read strobe
    logic [ADDR_W-1:0] flash_addr; // flash read address
    logic s1; // pin synchroniser stages
    logic s2;
    logic s3;
    logic pin_lvl; // filtered reset pin level
    logic core_rst; // core reset request
    logic periph_rst; // peripheral reset request
    logic port_rst; // port buffer reset request
    logic swbp; // software breakpoints valid
    logic brk_unrel; // break handling disturbed
    logic rst_risk; // reset may be incomplete
  } fsg_regs_t;
endpackage

// File: design/fsg_gate.sv
// security id gate with break aware reset control
module fsg_gate
  import fsg_pkg::*;
(
  input wire logic core_clk, // system clock, 10 mhz
  input wire logic srst, // synchronous reset, active high
  input wire logic dbg_start, // debugger asks for authentication, pulse
  input wire logic dbg_byte_valid, // candidate id byte present, pulse
  input wire logic [7:0] dbg_byte, // candidate id byte, ascending order
  output logic flash_rd, // flash read strobe, pulse
  output logic [ADDR_W-1:0] flash_addr, // flash read address
  input wire logic flash_rvalid, // flash read data valid, pulse
  input wire logic [7:0] flash_rdata, // flash read data
  output logic secured, // device locked, level
  output logic flash_read_en, // flash readout permitted, level
  output logic debug_en, // emulator permitted, level
  output logic auth_done, // attempt finished, pulse
  output logic auth_fail, // attempt rejected, pulse
  input wire logic reset_pin_n, // external reset pin, active low, async
  input wire logic cpu_in_break, // processor halted at a break
  input wire logic wdt_reset, // watchdog internal reset, pulse
  input wire logic int_reset, // other internal reset, pulse
  input wire logic hw_break, // hardware break taken, pulse
  input wire logic forced_break, // forced break taken, pulse
  input wire logic dma_flash_wr, // dma rewriting flash
  input wire logic ram_mon_rd, // ram monitor read in progress
  output logic core_reset, // reset to processor core
  output logic periph_reset, // reset to peripheral modules
  output logic port_buf_reset, // reset to port i/o buffers
  output logic swbp_valid, // software breakpoints active
  output logic brk_unreliable, // break may misbehave, sticky
  output logic rst_incomplete // reset may be partial, sticky
);
  fsg_regs_t r_reg; // all state
  fsg_regs_t r_next; // its next value
  logic pin_act; // reset pin asserted after filtering
  logic running; // program executing, not at a break
  logic any_rst; // any reset source this cycle

  // id byte address from its index
  function automatic logic [ADDR_W-1:0] id_addr(input logic [3:0] i);
    id_addr = ID_BASE + {{(ADDR_W-4){1'b0}}, i};
  endfunction

  assign pin_act = !r_reg.pin_lvl;
  assign running = !cpu_in_break;
  assign any_rst = pin_act | wdt_reset | int_reset;

  // next state logic
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    r_next.fail = 1'b0;
    r_next.flash_rd = 1'b0;
    // pin synchroniser, level counts when stages two and three agree
    r_next.s1 = reset_pin_n;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    if (r_reg.s2 == r_reg.s3) begin
      r_next.pin_lvl = r_reg.s3;
    end
    unique case (r_reg.st)
      ST_IDLE: begin
        // requests while busy are dropped, not queued
        if (dbg_start) begin
          r_next.st = ST_FETCH;
          r_next.idx = 4'h0;
          r_next.mismatch = 1'b0;
          r_next.perm = 1'b0;
        end
      end
      ST_FETCH: begin
        // one stored byte per step, lowest address first
        r_next.flash_rd = 1'b1;
        r_next.flash_addr = id_addr(r_reg.idx);
        r_next.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (flash_rvalid) begin
          r_next.stored = flash_rdata;
          if (r_reg.idx == ID_LAST_IDX) begin
            r_next.perm = flash_rdata[PERM_BIT];
          end
          r_next.st = ST_CMP;
        end
      end
      ST_CMP: begin
        if (dbg_byte_valid) begin
          // sticky: one bad byte spoils the whole attempt
          if (dbg_byte != r_reg.stored) begin
            r_next.mismatch = 1'b1;
          end
          if (r_reg.idx == ID_LAST_IDX) begin
            r_next.st = ST_DONE;
          end else begin
            r_next.idx = r_reg.idx + 4'h1;
            r_next.st = ST_FETCH;
          end
        end
      end
      ST_DONE: begin
        r_next.done = 1'b1;
        r_next.st = ST_IDLE;
        if (r_reg.mismatch) begin
          // a failed retry relocks a device already opened
          r_next.fail = 1'b1;
          r_next.secured = 1'b1;
          r_next.rd_en = 1'b0;
          r_next.dbg_en = 1'b0;
        end else begin
          r_next.secured = 1'b0;
          r_next.rd_en = 1'b1;
          r_next.dbg_en = r_reg.perm;
        end
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase
    // pin reset is masked for core and peripherals at a break
    r_next.core_rst = (pin_act & running) | wdt_reset | int_reset;
    r_next.periph_rst = (pin_act & running) | wdt_reset | int_reset;
    // port buffers follow the pin even when masked
    r_next.port_rst = pin_act;
    // a reset reaching the core relocks the gate
    if (r_next.core_rst) begin
      r_next.st = ST_IDLE;
      r_next.secured = SECURED_RST;
      r_next.rd_en = 1'b0;
      r_next.dbg_en = 1'b0;
    end
    // breakpoints lost on pin reset while running or on watchdog reset; a break restores, and wins
    if ((pin_act & running) | wdt_reset) begin
      r_next.swbp = 1'b0;
    end
    if (hw_break | forced_break) begin
      r_next.swbp = 1'b1;
    end
    // warning flags, cleared only by srst
    if (any_rst & running) begin
      r_next.brk_unrel = 1'b1;
    end
    if (any_rst & running & (dma_flash_wr | ram_mon_rd)) begin
      r_next.rst_risk = 1'b1;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.secured <= SECURED_RST;
      r_reg.swbp <= SWBP_RST;
      r_reg.s1 <= PIN_IDLE;
      r_reg.s2 <= PIN_IDLE;
      r_reg.s3 <= PIN_IDLE;
      r_reg.pin_lvl <= PIN_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign flash_rd = r_reg.flash_rd;
  assign flash_addr = r_reg.flash_addr;
  assign secured = r_reg.secured;
  assign flash_read_en = r_reg.rd_en;
  assign debug_en = r_reg.dbg_en;
  assign auth_done = r_reg.done;
  assign auth_fail = r_reg.fail;
  assign core_reset = r_reg.core_rst;
  assign periph_reset = r_reg.periph_rst;
  assign port_buf_reset = r_reg.port_rst;
  assign swbp_valid = r_reg.swbp;
  assign brk_unreliable = r_reg.brk_unrel;
  assign rst_incomplete = r_reg.rst_risk;

  // checks on the gate
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // helper sequences for the multi step checks
  sequence s_last_fetch;
    r_reg.st == ST_WAIT && flash_rvalid && r_reg.idx == ID_LAST_IDX;
  endsequence
  sequence s_pin_held;
    !reset_pin_n [*5];
  endsequence

  AST_FETCH_ADDR: assert property (flash_rd |-> flash_addr >= ID_BASE && flash_addr <= ID_LAST)
    else $error("id fetch outside id area");
  AST_PERM_BIT: assert property (s_last_fetch |=> r_reg.perm == $past(flash_rdata[PERM_BIT]))
    else $error("permission flag not from bit seven");
  // unlock and the done pulse are registered on the same edge
  AST_RELEASE: assert property ($fell(secured) |-> auth_done && !auth_fail)
    else $error("unlock without a full match");
  AST_OPEN_BOTH: assert property (!secured |-> flash_read_en)
    else $error("unlocked but flash read still barred");
  // perm is cleared at a new start while debug_en still holds the old verdict,
  // so the flag is judged only at the end of an attempt
  AST_FLAG_GATES: assert property (
    auth_done && !core_reset |-> debug_en == (!auth_fail && r_reg.perm))
    else $error("debug enable does not follow the flag");
  AST_DBG_OPEN: assert property (debug_en |-> !secured && flash_read_en)
    else $error("debug enabled while locked");
  AST_FAIL_LOCKED: assert property (auth_fail |-> secured && !debug_en)
    else $error("failed attempt left device open");
  AST_BREAK_MASK: assert property (pin_act && cpu_in_break && !wdt_reset && !int_reset
                                   |=> !core_reset && !periph_reset)
    else $error("pin reset reached core during break");
  AST_PORT_RST: assert property (s_pin_held |=> ##[1:2] port_buf_reset)
    else $error("port buffers not reset by pin");
  AST_SWBP_OFF: assert property (wdt_reset && !hw_break && !forced_break |=> !swbp_valid)
    else $error("breakpoint survived watchdog reset");
  AST_SWBP_BACK: assert property (hw_break || forced_break |=> swbp_valid)
    else $error("breakpoint not restored by break");
  AST_RUN_RST: assert property (wdt_reset && running |=> brk_unreliable)
    else $error("reset while running not flagged");
  // either risky activity counts, the flag does not say which one
  AST_DMA_RST: assert property (int_reset && running && (dma_flash_wr || ram_mon_rd)
                                |=> rst_incomplete)
    else $error("reset during flash dma or monitor read not flagged");
endmodule

// File: sim/fsg_flash_model.sv
// flash side model answering id byte reads of the gate
module fsg_flash_model
  import fsg_pkg::*;
(
  input wire logic core_clk, // system clock
  input wire logic flash_rd, // read strobe from gate
  input wire logic [ADDR_W-1:0] flash_addr, // read address from gate
  input wire logic [1:0] lat, // answer delay in cycles, 1..3
  input wire logic [79:0] id_code, // stored id, lowest address in low byte
  output logic flash_rvalid, // data valid, pulse
  output logic [7:0] flash_rdata // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0; // cycles left before the answer
  logic [3:0] idx; // id byte being read
  // one read at a time; data lines churn outside the valid cycle
  always @(posedge core_clk) begin
    flash_rvalid <= (cnt == 1);
    if (cnt == 1) begin
      flash_rdata <= id_code[idx*8 +: 8];
    end else begin
      flash_rdata <= ~flash_rdata; // stale data must never look valid
    end
    if (flash_rd) begin
      cnt <= int'(lat);
      idx <= 4'(flash_addr - ID_BASE);
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// File: sim/flash_security_id_debug_gate_test.sv
// self-checking bench for the security id gate
module flash_security_id_debug_gate_test
  import fsg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [79:0] GOOD = 80'hd423f1debc9a78563412; // flag byte bit 7 set
  logic core_clk = 1'b0, srst = 1'b1, dbg_start = 1'b0, dbg_byte_valid = 1'b0;
  logic [7:0] dbg_byte = 8'h00; // candidate byte
  logic reset_pin_n = 1'b1, cpu_in_break = 1'b0, wdt_reset = 1'b0, int_reset = 1'b0;
  logic hw_break = 1'b0, forced_break = 1'b0, dma_flash_wr = 1'b0, ram_mon_rd = 1'b0;
  logic [1:0] lat = 2'h1; // flash answer delay
  logic [79:0] id_code = GOOD; // id held in flash
  logic flash_rd, flash_rvalid, secured, flash_read_en, debug_en, auth_done, auth_fail;
  logic core_reset, periph_reset, port_buf_reset, swbp_valid, brk_unreliable;
  logic rst_incomplete;
  logic [ADDR_W-1:0] flash_addr; // read address
  logic [7:0] flash_rdata; // read data
  int failures = 0;
  int check_count = 0;
  fsg_gate dut (
    .core_clk(core_clk),
    .srst(srst),
    .dbg_start(dbg_start),
    .dbg_byte_valid(dbg_byte_valid),
    .dbg_byte(dbg_byte),
    .flash_rd(flash_rd),
    .flash_addr(flash_addr),
    .flash_rvalid(flash_rvalid),
    .flash_rdata(flash_rdata),
    .secured(secured),
    .flash_read_en(flash_read_en),
    .debug_en(debug_en),
    .auth_done(auth_done),
    .auth_fail(auth_fail),
    .reset_pin_n(reset_pin_n),
    .cpu_in_break(cpu_in_break),
    .wdt_reset(wdt_reset),
    .int_reset(int_reset),
    .hw_break(hw_break),
    .forced_break(forced_break),
    .dma_flash_wr(dma_flash_wr),
    .ram_mon_rd(ram_mon_rd),
    .core_reset(core_reset),
    .periph_reset(periph_reset),
    .port_buf_reset(port_buf_reset),
    .swbp_valid(swbp_valid),
    .brk_unreliable(brk_unreliable),
    .rst_incomplete(rst_incomplete)
  );
  fsg_flash_model fm (
    .core_clk(core_clk),
    .flash_rd(flash_rd),
    .flash_addr(flash_addr),
    .lat(lat),
    .id_code(id_code),
    .flash_rvalid(flash_rvalid),
    .flash_rdata(flash_rdata)
  );
  // free running clock, 100 ns period
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  // all input changes land 10 ns after the rising edge
  task automatic tick();
    @(posedge core_clk);
    #10;
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      failures++;
    end
  endtask
  // bounded wait for a design pulse or level
  task automatic wait_hi(ref logic s, input string n);
    int k;
    k = 0;
    while (s !== 1'b1 && k < 40) begin
      tick();
      k++;
    end
    if (s !== 1'b1) begin
      $display("BAD %s exp 1 got timeout", n);
      failures++;
      complete_run();
    end
  endtask
  // full attempt: start, then ten read, answer, byte rounds
  task automatic auth(input logic [79:0] code, input logic ok, input logic dbg);
    dbg_start = 1'b1;
    tick();
    dbg_start = 1'b0;
    for (int i = 0; i < 10; i++) begin
      wait_hi(flash_rd, "flash_rd");
      chk("flash_addr", ID_BASE + 24'(i), flash_addr);
      wait_hi(flash_rvalid, "flash_rvalid");
      tick();
      dbg_byte = code[i*8 +: 8];
      dbg_byte_valid = 1'b1;
      tick();
      dbg_byte_valid = 1'b0;
    end
    wait_hi(auth_done, "auth_done");
    chk("auth_fail", 24'(!ok), 24'(auth_fail));
    chk("secured", 24'(!ok), 24'(secured));
    chk("flash_read_en", 24'(ok), 24'(flash_read_en));
    chk("debug_en", 24'(ok & dbg), 24'(debug_en));
    tick();
  endtask
  // pin reset held low for ten cycles, with or without a break
  task automatic pin_pulse(input logic brk);
    cpu_in_break = brk;
    reset_pin_n = 1'b0;
    repeat (10) tick();
    chk("port_buf_reset", 24'h1, 24'(port_buf_reset));
    chk("core_reset", 24'(!brk), 24'(core_reset));
    chk("periph_reset", 24'(!brk), 24'(periph_reset));
    chk("swbp_valid", 24'(brk), 24'(swbp_valid));
    reset_pin_n = 1'b1;
    repeat (10) tick();
  endtask
  initial begin
    repeat (20) tick();
    srst = 1'b0;
    chk("secured", 24'h1, 24'(secured));
    chk("swbp_valid", 24'h1, 24'(swbp_valid));
    auth(GOOD, 1'b1, 1'b1);
    lat = 2'h3; // slow flash answers
    auth(GOOD ^ 80'h01000000000000000000, 1'b0, 1'b0);
    id_code = GOOD & ~80'h80000000000000000000; // flag cleared
    auth(id_code, 1'b1, 1'b0);
    pin_pulse(1'b1);
    chk("brk_unreliable", 24'h0, 24'(brk_unreliable));
    cpu_in_break = 1'b0;
    wdt_reset = 1'b1;
    tick();
    wdt_reset = 1'b0;
    chk("core_reset", 24'h1, 24'(core_reset));
    chk("swbp_valid", 24'h0, 24'(swbp_valid));
    chk("brk_unreliable", 24'h1, 24'(brk_unreliable));
    hw_break = 1'b1;
    tick();
    hw_break = 1'b0;
    chk("swbp_valid", 24'h1, 24'(swbp_valid));
    pin_pulse(1'b0);
    forced_break = 1'b1;
    tick();
    forced_break = 1'b0;
    chk("swbp_valid", 24'h1, 24'(swbp_valid));
    chk("rst_incomplete", 24'h0, 24'(rst_incomplete));
    ram_mon_rd = 1'b1;
    int_reset = 1'b1;
    tick();
    int_reset = 1'b0;
    ram_mon_rd = 1'b0;
    tick();
    chk("rst_incomplete", 24'h1, 24'(rst_incomplete));
    dma_flash_wr = 1'b1;
    tick();
    chk("secured", 24'h1, 24'(secured));
    complete_run();
  end
endmodule
